// ### pbw_monitor.sv
// assertions for the boost and network-loss outputs
`timescale 1ns/10ps
module pbw_mon (
   input wire logic       clk_in,
   input wire logic       rst_b_in,
   input wire logic       ce_in,
   input wire logic       run_mode_in,
   input wire logic [9:0] process_variable_in,
   input wire logic [9:0] setpoint_value_in,
   input wire logic [9:0] pv_high_limit_in,
   input wire logic [9:0] pv_low_limit_in,
   input wire logic       net_ctrl_active_in,
   input wire logic       frame_ok_in,
   input wire logic [1:0] comm_error_response_sel_in,
   input wire logic       boost_stage_out,
   input wire logic       net_loss_out,
   input wire logic       comm_trip_out,
   input wire logic       decel_stop_out,
   input wire logic       coast_stop_out,
   input wire logic       sp_above_pv_out
);
   wire [1:0] s   = comm_error_response_sel_in;
   wire       run = ce_in && run_mode_in;
   wire       lo  = process_variable_in < pv_low_limit_in;
   wire       hi  = process_variable_in > pv_high_limit_in;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_idle; (ce_in && !net_ctrl_active_in) [*2]; endsequence
   property p_on; run && lo |=> boost_stage_out; endproperty
   a_on: assert property (p_on) else $error("boost not set");
   property p_off; run && !lo && hi |=> !boost_stage_out; endproperty
   a_off: assert property (p_off) else $error("boost not cleared");
   property p_stop; ce_in && !run_mode_in |=> !boost_stage_out; endproperty
   a_stop: assert property (p_stop) else $error("boost in stop");
   property p_hold; run && !lo && !hi |=> $stable(boost_stage_out); endproperty
   a_hold: assert property (p_hold) else $error("boost moved");
   property p_sp; ce_in |=> sp_above_pv_out ==
      $past(setpoint_value_in > process_variable_in); endproperty
   a_sp: assert property (p_sp) else $error("compare wrong");
   property p_resp; $rose(net_loss_out) |-> {comm_trip_out, decel_stop_out,
      coast_stop_out} == {!$past(s[1]), $past(s) == 2'h1,
      $past(s[0]) == $past(s[1])}; endproperty
   a_resp: assert property (p_resp) else $error("bad response");
   property p_frame; ce_in && frame_ok_in ##1 ce_in |=> !net_loss_out;
   endproperty
   a_frame: assert property (p_frame) else $error("loss kept");
   property p_idle; s_idle |=> !net_loss_out; endproperty
   a_idle: assert property (p_idle) else $error("loss idle");
   property p_freeze; !ce_in |=> $stable({boost_stage_out, net_loss_out});
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved");
endmodule : pbw_mon
bind pbw_top pbw_mon u_mon (.*);

// ### pbw_partner.sv
// far side: helper drive and network master
`timescale 1ns/10ps
module pbw_partner (
   input  wire logic clk_in,
   input  wire logic run_forward_cmd_in,
   input  wire logic send_in,
   output logic      frame_ok_out,
   output logic      helper_run_out
);
   logic [2:0] gap_q = 3'h0;
   initial frame_ok_out = 1'b0;
   assign helper_run_out = run_forward_cmd_in;
   // one frame every 5 clocks keeps well inside the watchdog period
   always @(posedge clk_in)
   begin
      gap_q <= (gap_q == 3'h4) ? 3'h0 : gap_q + 3'h1;
      frame_ok_out <= send_in && (gap_q == 3'h0);
   end
endmodule : pbw_partner

// ### pbw_pkg.sv
// constants shared by the boost-stage and network watchdog outputs
package pbw_pkg;
   // output option codes
   localparam logic [7:0]  OPT_BOOST_STAGE = 8'h07;
   localparam logic [7:0]  OPT_NET_LOSS    = 8'h08;
   // percent values carried as tenths of a percent, 0..1000
   localparam int          PCT_W           = 10;
   localparam logic [9:0]  PCT_FULL_SCALE  = 10'h3e8;
   // communication error response selection codes
   localparam logic [1:0]  RESP_TRIP       = 2'h0;
   localparam logic [1:0]  RESP_DECEL_TRIP = 2'h1;
   localparam logic [1:0]  RESP_NONE       = 2'h2;
   localparam logic [1:0]  RESP_COAST      = 2'h3;
   // trip code reported on a network time-out
   localparam logic [7:0]  COMM_TRIP_CODE  = 8'h60;
   // watchdog timebase: one tick per millisecond at 200 MHz
   localparam int          CLK_PERIOD_PS   = 5000;
   localparam int          TICK_TIME_US    = 1000;
   localparam int          TICK_CYCLES     = TICK_TIME_US * 1000000
                                             / CLK_PERIOD_PS;
   localparam int          TICK_W          = 18;
   localparam int          PERIOD_W        = 16;
   localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h0000;
endpackage : pbw_pkg

// ### pbw_tb_top.sv
// self-checking bench for pbw_top
`timescale 1ns/10ps
module pbw_tb_top;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        ce = 1'b1;
   logic [15:0] per = 16'h0002;
   logic        run = 1'b0;
   logic        act = 1'b0;
   logic        send = 1'b0;
   logic        trst = 1'b0;
   logic [7:0]  opt = 8'h07;
   logic [1:0]  sel = 2'h0;
   logic [9:0]  pv = 10'h000;
   logic        boost, loss, term, trip, decel, coast, spa, frame, help;
   logic [7:0]  code;
   logic [11:0] rows [8] = '{12'h8c9, 12'hbe9, 12'hd79, 12'hd7a,
                             12'ha58, 12'ha57, 12'h0c8, 12'hbe8};
   int          miscompares = 0;
   int          check_count = 0;
   int          cyc = 0;
   int          n;
   int          c;
   always #2.5 clk = ~clk;
   pbw_top #(.TICK_CYCLES(4)) dut (.clk_in(clk), .rst_b_in(rst_b),
      .ce_in(ce), .out_option_in(opt), .run_mode_in(run),
      .process_variable_in(pv), .setpoint_value_in(10'h190),
      .pv_high_limit_in(10'h2bc), .pv_low_limit_in(10'h12c),
      .net_ctrl_active_in(act), .frame_ok_in(frame),
      .comm_error_response_sel_in(sel), .comm_timeout_period_in(per),
      .trip_reset_in(trst), .boost_stage_out(boost), .net_loss_out(loss),
      .term_out(term), .comm_trip_out(trip), .trip_code_out(code),
      .decel_stop_out(decel), .coast_stop_out(coast), .sp_above_pv_out(spa));
   pbw_partner far (.clk_in(clk), .run_forward_cmd_in(boost),
      .send_in(send), .frame_ok_out(frame), .helper_run_out(help));
   task step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : step
   task check(input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e)
      begin
         miscompares++;
         $display("mismatch %0t got %h want %h", $time, s, e);
      end
   endtask : check
   task end_sim;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         miscompares++;
         end_sim();
      end
   end
   initial
   begin
      step(12);
      rst_b = 1'b1;
      step(1);
      check({loss, trip, decel, coast, boost, term}, 8'h00);
      check(code, 8'h00);
      for (n = 0; n < 8; n++)
      begin
         run = rows[n][11];
         pv = rows[n][10:1];
         step(2);
         check(boost, rows[n][0]);
         check({term, help}, {2{rows[n][0]}});
         check(spa, pv < 10'h190);
      end
      ce = 1'b0;
      pv = 10'h064;
      step(3);
      check({boost, term, spa}, 8'h00);
      ce = 1'b1;
      step(2);
      check({boost, term, spa}, 8'h07);
      rst_b = 1'b0;
      step(1);
      check({boost, term, spa, loss}, 8'h00);
      rst_b = 1'b1;
      step(1);
      check({boost, term, help}, 8'h07);
      opt = 8'h08;
      act = 1'b1;
      send = 1'b1;
      step(60);
      check({loss, term}, 8'h00);
      for (n = 0; n < 4; n++)
      begin
         sel = n[1:0];
         trst = 1'b1;
         send = 1'b1;
         step(12);
         check({loss, trip}, 8'h00);
         trst = 1'b0;
         for (c = 0; c < 9 && frame !== 1'b1; c++)
            step(1);
         send = 1'b0;
         for (c = 0; c < 30 && loss !== 1'b1; c++)
            step(1);
         check(c[7:0], 8'h0b);
         check({term, trip, decel}, {1'b1, !sel[1], sel == 2'h1});
         check(coast, sel[0] == sel[1]);
         check(code, sel[1] ? 8'h00 : 8'h60);
      end
      act = 1'b0;
      step(30);
      check(loss, 1'b0);
      per = 16'h0000;
      trst = 1'b1;
      act = 1'b1;
      step(30);
      check({loss, term}, 8'h00);
      check({trip, decel, coast}, 8'h00);
      end_sim();
   end
endmodule : pbw_tb_top

// ### pbw_top.sv
// boost-stage hysteresis output and network-loss watchdog output
//
// Notes on behaviour
// - boost on in run with pv below low
// - boost off when pv rises above high
// - boost off on run to stop change
// - between limits boost keeps previous state
// - setpoint and limits compared in percent units
// - limits give no alarm; boost is no alarm
// - net-loss output on silence past a nonzero watchdog period
// - net-loss stays off while frames refresh watchdog
// - time-out response: trip code, decel or coast
`timescale 1ns/10ps
module pbw_top #(
   parameter int TICK_CYCLES = pbw_pkg::TICK_CYCLES
) (
   input  wire logic                          clk_in,
   input  wire logic                          rst_b_in,
   input  wire logic                          ce_in,
   input  wire logic [7:0]                    out_option_in,
   input  wire logic                          run_mode_in,
   input  wire logic [pbw_pkg::PCT_W-1:0]     process_variable_in,
   input  wire logic [pbw_pkg::PCT_W-1:0]     setpoint_value_in,
   input  wire logic [pbw_pkg::PCT_W-1:0]     pv_high_limit_in,
   input  wire logic [pbw_pkg::PCT_W-1:0]     pv_low_limit_in,
   input  wire logic                          net_ctrl_active_in,
   input  wire logic                          frame_ok_in,
   input  wire logic [1:0]                    comm_error_response_sel_in,
   input  wire logic [pbw_pkg::PERIOD_W-1:0]  comm_timeout_period_in,
   input  wire logic                          trip_reset_in,
   output      logic                          boost_stage_out,
   output      logic                          net_loss_out,
   output      logic                          term_out,
   output      logic                          comm_trip_out,
   output      logic [7:0]                    trip_code_out,
   output      logic                          decel_stop_out,
   output      logic                          coast_stop_out,
   output      logic                          sp_above_pv_out
);
   // one-hot codes let each output pin be a single state flip-flop
   typedef enum logic [1:0] {
      BOOST_IDLE   = 2'b01,
      BOOST_ACTIVE = 2'b10
   } pbw_boost_t;

   typedef enum logic [1:0] {
      NET_HEALTHY = 2'b01,
      NET_LOST    = 2'b10
   } pbw_net_t;

   typedef struct packed {
      logic       run;
      pbw_boost_t boost;
      pbw_net_t   net;
      logic       term;
      logic       trip;
      logic [7:0] code;
      logic       decel;
      logic       coast;
      logic       sp_above;
   } pbw_st_t;

   // reset lands in legal one-hot codes, not all zeros
   localparam pbw_st_t ST_RST = '{
      run:      1'b0,
      boost:    BOOST_IDLE,
      net:      NET_HEALTHY,
      term:     1'b0,
      trip:     1'b0,
      code:     8'h00,
      decel:    1'b0,
      coast:    1'b0,
      sp_above: 1'b0
   };

   pbw_st_t s_q;
   pbw_st_t s_d;
   logic    wd_expired;
   logic    pv_low;
   logic    pv_high;
   logic    run_to_stop;
   logic    loss_rise;
   logic    resp_clear;

   pbw_wdog #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_wdog (
      .clk_in       (clk_in),
      .rst_b_in     (rst_b_in),
      .ce_in        (ce_in),
      .active_in    (net_ctrl_active_in),
      .frame_ok_in  (frame_ok_in),
      .period_ms_in (comm_timeout_period_in),
      .expired_out  (wd_expired)
   );

   // all three quantities share one percent scale, so plain compares
   assign pv_low      = process_variable_in < pv_low_limit_in;
   assign pv_high     = process_variable_in > pv_high_limit_in;
   // run is registered so that the run to stop change can be seen
   assign run_to_stop = s_q.run && !run_mode_in;
   assign loss_rise   = wd_expired && (s_q.net == NET_HEALTHY);
   // an expiry still pending keeps the response until the link is back
   assign resp_clear  = trip_reset_in && !wd_expired;

   always_comb
   begin
      s_d          = s_q;
      s_d.run      = run_mode_in;
      s_d.sp_above = setpoint_value_in > process_variable_in;

      // hysteresis: inside the band the state is left alone
      case (s_q.boost)
         BOOST_IDLE:
         begin
            if (run_mode_in && pv_low)
            begin
               s_d.boost = BOOST_ACTIVE;
            end
         end
         BOOST_ACTIVE:
         begin
            // leaving run clears boost whatever the pv level
            if (run_to_stop || !run_mode_in)
            begin
               s_d.boost = BOOST_IDLE;
            end
            else if (pv_high && !pv_low)
            begin
               s_d.boost = BOOST_IDLE;
            end
         end
         default:
         begin
            s_d.boost = BOOST_IDLE;
         end
      endcase

      // net loss follows the watchdog; the response latches on its rise
      case (s_q.net)
         NET_HEALTHY:
         begin
            if (wd_expired)
            begin
               s_d.net = NET_LOST;
            end
         end
         NET_LOST:
         begin
            if (!wd_expired)
            begin
               s_d.net = NET_HEALTHY;
            end
         end
         default:
         begin
            s_d.net = NET_HEALTHY;
         end
      endcase

      // time-out reaction latches until cleared by trip reset
      if (resp_clear)
      begin
         s_d.trip  = 1'b0;
         s_d.code  = 8'h00;
         s_d.decel = 1'b0;
         s_d.coast = 1'b0;
      end
      // set placed after the clear so a new time-out always wins
      if (loss_rise)
      begin
         case (comm_error_response_sel_in)
            pbw_pkg::RESP_TRIP:
            begin
               s_d.trip  = 1'b1;
               s_d.code  = pbw_pkg::COMM_TRIP_CODE;
               s_d.coast = 1'b1;
            end
            pbw_pkg::RESP_DECEL_TRIP:
            begin
               s_d.trip  = 1'b1;
               s_d.code  = pbw_pkg::COMM_TRIP_CODE;
               s_d.decel = 1'b1;
            end
            pbw_pkg::RESP_COAST:
            begin
               s_d.coast = 1'b1;
            end
            default:
            begin
               // no-action selection: only the loss output, and the terminal under its option code, report it
               s_d.trip = s_q.trip;
            end
         endcase
      end

      // terminal follows the function picked by its option code
      case (out_option_in)
         pbw_pkg::OPT_BOOST_STAGE:
         begin
            s_d.term = (s_d.boost == BOOST_ACTIVE);
         end
         pbw_pkg::OPT_NET_LOSS:
         begin
            s_d.term = (s_d.net == NET_LOST);
         end
         default:
         begin
            s_d.term = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
         s_q <= ST_RST;
      else if (ce_in)
         s_q <= s_d;
   end

   // boost drives the helper run input only, never an alarm
   assign boost_stage_out = s_q.boost[1];
   assign net_loss_out    = s_q.net[1];
   assign term_out        = s_q.term;
   assign comm_trip_out   = s_q.trip;
   assign trip_code_out   = s_q.code;
   assign decel_stop_out  = s_q.decel;
   assign coast_stop_out  = s_q.coast;
   assign sp_above_pv_out = s_q.sp_above;
endmodule : pbw_top

// ### pbw_wdog.sv
// network activity watchdog timer, millisecond resolution
`timescale 1ns/10ps
module pbw_wdog #(
   parameter int TICK_CYCLES = pbw_pkg::TICK_CYCLES
) (
   input  wire logic                          clk_in,
   input  wire logic                          rst_b_in,
   input  wire logic                          ce_in,
   input  wire logic                          active_in,
   input  wire logic                          frame_ok_in,
   input  wire logic [pbw_pkg::PERIOD_W-1:0]  period_ms_in,
   output      logic                          expired_out
);
   typedef struct packed {
      logic [pbw_pkg::TICK_W-1:0]   tick;
      logic [pbw_pkg::PERIOD_W-1:0] ms;
      logic                         expired;
   } pbw_wdog_st_t;

   pbw_wdog_st_t s_q;
   pbw_wdog_st_t s_d;

   always_comb
   begin
      s_d = s_q;
      if (!active_in || frame_ok_in)
      begin
         // a good frame restarts the count from zero
         s_d.tick    = '0;
         s_d.ms      = '0;
         s_d.expired = 1'b0;
      end
      else if (!s_q.expired)
      begin
         if (s_q.tick == pbw_pkg::TICK_W'(TICK_CYCLES - 1))
         begin
            s_d.tick = '0;
            s_d.ms   = s_q.ms + 1'b1;
         end
         else
            s_d.tick = s_q.tick + 1'b1;
         // silence longer than a nonzero period expires the watchdog; a period of zero never expires
         if (period_ms_in != '0 && s_q.ms >= period_ms_in)
            s_d.expired = 1'b1;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
         s_q <= '0;
      else if (ce_in)
         s_q <= s_d;
   end

   assign expired_out = s_q.expired;
endmodule : pbw_wdog
